/* File: include/ddr_tp_pkg.sv */
// Shared constants for the burst throughput master and the memory end
package ddr_tp_pkg;
  localparam int DATA_W = 64;
  localparam int ADDR_W = 32;
  localparam logic [7:0] BURST_LEN = 8'h0F; // Sixteen beats per burst
  localparam logic [3:0] LAST_BEAT = 4'hF;
  localparam logic [31:0] BURST_BYTES = 32'h00000080;
  localparam logic [31:0] BEAT_BYTES = 32'h00000008;
  localparam logic [31:0] BASE_ADDR = 32'h00000000;
  localparam logic [2:0] BEAT_SIZE = 3'h3; // Eight bytes per beat
  localparam logic [1:0] BURST_INCR = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [2:0] SIZE_MAX = 3'h4; // Size code 4 is 32 KB
  localparam logic [11:0] BURSTS_2KB = 12'h010; // 2 KB in 128-byte bursts
  localparam int MEM_CLK_RATIO = 2; // Memory clock over fabric clock
  localparam int DRAM_BL = 8;
  localparam int RD_QUEUE = 4; // Queued read addresses
  localparam int FIFO_DEPTH = 8;
  localparam int MEM_WORDS = 256;
  localparam logic [31:0] MEM_LIMIT = 32'h00008000;
endpackage

/* File: include/ddr_axi_if.sv */
// AXI channels between the throughput master and the memory end
`timescale 1ns/1ps
interface ddr_axi_if;
  logic [31:0] awaddr;
  logic [7:0] awlen;
  logic [2:0] awsize;
  logic [1:0] awburst;
  logic awvalid;
  logic awready;
  logic [63:0] wdata;
  logic [7:0] wstrb;
  logic wlast;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [31:0] araddr;
  logic [7:0] arlen;
  logic [2:0] arsize;
  logic [1:0] arburst;
  logic arvalid;
  logic arready;
  logic [63:0] rdata;
  logic [1:0] rresp;
  logic rlast;
  logic rvalid;
  logic rready;
  modport master (
    output awaddr, awlen, awsize, awburst, awvalid, input awready,
    output wdata, wstrb, wlast, wvalid, input wready,
    input bresp, bvalid, output bready,
    output araddr, arlen, arsize, arburst, arvalid, input arready,
    input rdata, rresp, rlast, rvalid, output rready
  );
  modport slave (
    input awaddr, awlen, awsize, awburst, awvalid, output awready,
    input wdata, wstrb, wlast, wvalid, output wready,
    output bresp, bvalid, input bready,
    input araddr, arlen, arsize, arburst, arvalid, output arready,
    output rdata, rresp, rlast, rvalid, input rready
  );
endinterface

/* File: hdl/ddr_tp_mem.sv */
// Memory end: AXI slave with write data buffer and queued read addresses
`timescale 1ns/1ps
module ddr_tp_fifo #(
  parameter int WIDTH = 65,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output logic [WIDTH-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] cnt;
  wire push = i_valid && o_ready && i_ce;
  wire pop = o_valid && i_ready && i_ce;

  // Honest flags from the fill count
  assign o_ready = cnt != (PW+1)'(DEPTH);
  assign o_valid = cnt != '0;
  assign o_data = mem[rd_ptr];

  // Storage and pointers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wr_ptr <= PW'((wr_ptr + 1'b1) % DEPTH);
      end
      if (pop) begin
        rd_ptr <= PW'((rd_ptr + 1'b1) % DEPTH);
      end
      cnt <= cnt + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Data words carry no reset
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end
endmodule

module ddr_tp_mem (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_stall,
  output logic [2:0] o_rd_queued,
  ddr_axi_if.slave axi
);
  logic [63:0] mem [ddr_tp_pkg::MEM_WORDS];
  logic aw_full;
  logic [31:0] aw_addr;
  logic aw_bad;
  logic [1:0] next_bresp;
  logic [31:0] q_addr [ddr_tp_pkg::RD_QUEUE];
  logic [7:0] q_len [ddr_tp_pkg::RD_QUEUE];
  logic [1:0] q_head;
  logic [1:0] q_tail;
  logic [2:0] q_cnt;
  logic rd_act;
  logic [31:0] rd_addr;
  logic [7:0] rd_len;
  logic [7:0] rd_beat;
  logic rd_bad;
  logic [63:0] f_data;
  logic f_last;
  logic f_valid;

  // Word index and range check shared by both paths
  function automatic logic [7:0] word_idx(input logic [31:0] a);
    word_idx = a[10:3];
  endfunction
  function automatic logic bad_req(input logic [31:0] a, input logic [7:0] len);
    bad_req = (a >= ddr_tp_pkg::MEM_LIMIT) || (len > ddr_tp_pkg::BURST_LEN);
  endfunction

  // Handshake decode
  wire aw_fire = axi.awvalid && axi.awready && i_ce;
  wire f_ready = aw_full && !axi.bvalid && !i_stall;
  wire f_pop = f_valid && f_ready && i_ce;
  wire ar_fire = axi.arvalid && axi.arready && i_ce;
  wire load = !rd_act && (q_cnt != 3'h0) && i_ce;
  wire r_fire = axi.rvalid && axi.rready && i_ce;
  wire r_end = r_fire && axi.rlast;
  assign axi.awready = !aw_full;
  assign axi.arready = q_cnt != 3'(ddr_tp_pkg::RD_QUEUE);
  assign axi.rvalid = rd_act;
  assign axi.rlast = rd_act && (rd_beat == rd_len);
  assign axi.rdata = mem[word_idx(rd_addr)];
  assign axi.rresp = rd_bad ? ddr_tp_pkg::RESP_SLVERR : ddr_tp_pkg::RESP_OKAY;
  assign next_bresp = aw_bad ? ddr_tp_pkg::RESP_SLVERR : ddr_tp_pkg::RESP_OKAY;

  // Write data buffer between the W channel and the array
  ddr_tp_fifo #(.WIDTH(65), .DEPTH(ddr_tp_pkg::FIFO_DEPTH)) u_wbuf (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_data({axi.wlast, axi.wdata}),
    .i_valid(axi.wvalid),
    .o_ready(axi.wready),
    .o_data({f_last, f_data}),
    .o_valid(f_valid),
    .i_ready(f_ready)
  );

  // Write address slot and response, sent once the last beat is drained
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
      aw_bad <= 1'b0;
      axi.bvalid <= 1'b0;
      axi.bresp <= ddr_tp_pkg::RESP_OKAY;
    end else if (i_ce) begin
      if (aw_fire) begin
        aw_full <= 1'b1;
        aw_addr <= axi.awaddr;
        aw_bad <= bad_req(axi.awaddr, axi.awlen);
      end else if (f_pop) begin
        aw_addr <= aw_addr + ddr_tp_pkg::BEAT_BYTES;
        aw_full <= !f_last;
      end
      if (f_pop && f_last) begin
        axi.bvalid <= 1'b1;
        axi.bresp <= next_bresp;
      end else if (axi.bready) begin
        axi.bvalid <= 1'b0;
      end
    end
  end

  // Array writes, one beat per drained word of an in-range burst
  always_ff @(posedge i_clk) begin
    if (f_pop && !aw_bad) begin
      mem[word_idx(aw_addr)] <= f_data;
    end
  end

  // Read address queue
  always_ff @(posedge i_clk) begin
    if (ar_fire) begin
      q_addr[q_tail] <= axi.araddr;
      q_len[q_tail] <= axi.arlen;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q_head <= '0;
      q_tail <= '0;
      q_cnt <= '0;
      o_rd_queued <= '0;
    end else if (i_ce) begin
      q_tail <= q_tail + 2'(ar_fire);
      q_head <= q_head + 2'(load);
      q_cnt <= q_cnt + 3'(ar_fire) - 3'(load);
      o_rd_queued <= q_cnt + 3'(ar_fire) - 3'(load);
    end
  end

  // Read engine: a burst in service frees its queue slot early
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_act <= 1'b0;
      rd_addr <= '0;
      rd_len <= '0;
      rd_beat <= '0;
      rd_bad <= 1'b0;
    end else if (load) begin
      rd_act <= 1'b1;
      rd_addr <= q_addr[q_head];
      rd_len <= q_len[q_head];
      rd_beat <= '0;
      rd_bad <= bad_req(q_addr[q_head], q_len[q_head]);
    end else if (r_fire) begin
      rd_act <= !r_end;
      rd_addr <= rd_addr + ddr_tp_pkg::BEAT_BYTES;
      rd_beat <= rd_beat + 8'h01;
    end
  end
endmodule

/* File: hdl/ddr_tp_master.sv */
// Burst master: writes a counting pattern, reads it back, times each run
//
// What this block does
// - Transfer sizes 2, 4, 8, 16, 32 KB
// - Write counting pattern, report clock count
// - Reads compared to pattern, mismatch lights LED
// - Memory clock twice the fabric clock
// - Data path 64 bits wide
// - Memory side bursts of 4, 8 or 16
// - Slave accepts bursts up to sixteen beats
// - Every burst sixteen beats, DRAM burst eight
// - Write-last only on final beat of burst
// - Write response only after all data beats
// - Next write address before previous response
// - Watch write responses, stop on error
// - Up to five reads outstanding, four queued plus one in service
// - Five read addresses accepted back to back
// - Keep issuing reads while address ready holds
// - Long sequential runs, no single-beat bursts
// - Addresses start at zero, step 128
// - Write count: first address to last write-last
// - Read count: first address to last read-last
// - Error LED output active low
`timescale 1ns/1ps
module ddr_tp_master (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_wr_cmd,
  input wire logic i_rd_cmd,
  input wire logic [2:0] i_size,
  output logic o_busy,
  output logic o_done,
  output logic [31:0] o_count,
  output logic o_led_err_n,
  output logic o_bresp_err,
  ddr_axi_if.master axi
);
  typedef enum {ST_IDLE, ST_WRITE, ST_WR_RESP, ST_READ} state_t;
  state_t state;
  state_t next_state;
  logic [11:0] nbursts;
  logic [11:0] aw_cnt;
  logic [11:0] w_burst;
  logic [11:0] b_cnt;
  logic [11:0] ar_cnt;
  logic [11:0] r_burst;
  logic [3:0] w_beat;
  logic [3:0] r_beat;
  logic running;
  logic err;
  logic [2:0] size_code;
  logic [11:0] next_nbursts;

  // ----------------------------------------------------------------
  // Address and pattern helpers
  // ----------------------------------------------------------------
  // Burst n starts at base plus n times 128 bytes
  function automatic logic [31:0] burst_addr(input logic [11:0] n);
    burst_addr = ddr_tp_pkg::BASE_ADDR + 32'(32'(n) * ddr_tp_pkg::BURST_BYTES);
  endfunction
  // Pattern word is the running beat number of the operation
  function automatic logic [63:0] pattern(input logic [11:0] n, input logic [3:0] beat);
    pattern = {48'h0, n, beat};
  endfunction

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Size code clamps at 32 KB; bursts double per step
  assign size_code = (i_size > ddr_tp_pkg::SIZE_MAX) ? ddr_tp_pkg::SIZE_MAX : i_size;
  assign next_nbursts = ddr_tp_pkg::BURSTS_2KB << size_code;
  wire start_wr = (state == ST_IDLE) && i_wr_cmd && i_ce;
  wire start_rd = (state == ST_IDLE) && !i_wr_cmd && i_rd_cmd && i_ce;

  // ----------------------------------------------------------------
  // Channel handshakes
  // ----------------------------------------------------------------
  wire aw_fire = axi.awvalid && axi.awready && i_ce;
  wire w_fire = axi.wvalid && axi.wready && i_ce;
  wire b_fire = axi.bvalid && axi.bready && i_ce;
  wire ar_fire = axi.arvalid && axi.arready && i_ce;
  wire r_fire = axi.rvalid && axi.rready && i_ce;
  wire b_bad = b_fire && (axi.bresp != ddr_tp_pkg::RESP_OKAY);
  wire aw_stop = o_bresp_err || b_bad;
  wire aw_all = (aw_cnt == nbursts) || aw_stop;
  wire w_end = w_fire && axi.wlast;
  wire w_final = w_end && ((w_burst + 12'h001) == aw_cnt) && aw_all;
  wire r_final = r_fire && axi.rlast && ((r_burst + 12'h001) == nbursts);
  wire r_wrong = r_fire && ((axi.rdata != pattern(r_burst, r_beat))
                 || (axi.rresp != ddr_tp_pkg::RESP_OKAY));

  // ----------------------------------------------------------------
  // AXI request outputs
  // ----------------------------------------------------------------
  // Write addresses run ahead of responses; data follows its address
  assign axi.awvalid = (state == ST_WRITE) && (aw_cnt != nbursts) && !o_bresp_err;
  assign axi.awaddr = burst_addr(aw_cnt);
  assign axi.awlen = ddr_tp_pkg::BURST_LEN;
  assign axi.awsize = ddr_tp_pkg::BEAT_SIZE;
  assign axi.awburst = ddr_tp_pkg::BURST_INCR;
  assign axi.wvalid = (state == ST_WRITE) && (w_burst != aw_cnt);
  assign axi.wdata = pattern(w_burst, w_beat);
  assign axi.wstrb = 8'hFF;
  assign axi.wlast = axi.wvalid && (w_beat == ddr_tp_pkg::LAST_BEAT);
  assign axi.bready = (state == ST_WRITE) || (state == ST_WR_RESP);
  // Read addresses advance as long as the slave keeps taking them
  assign axi.arvalid = (state == ST_READ) && (ar_cnt != nbursts);
  assign axi.araddr = burst_addr(ar_cnt);
  assign axi.arlen = ddr_tp_pkg::BURST_LEN;
  assign axi.arsize = ddr_tp_pkg::BEAT_SIZE;
  assign axi.arburst = ddr_tp_pkg::BURST_INCR;
  assign axi.rready = state == ST_READ;

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  assign o_busy = state != ST_IDLE;
  assign o_led_err_n = !err;

  // ----------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_wr) begin
          next_state = ST_WRITE;
        end else if (start_rd) begin
          next_state = ST_READ;
        end
      end
      ST_WRITE: begin
        if (w_final) begin
          next_state = ST_WR_RESP;
        end
      end
      ST_WR_RESP: begin
        if ((b_cnt + 12'(b_fire)) == aw_cnt) begin
          next_state = ST_IDLE;
        end
      end
      ST_READ: begin
        if (r_final) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State register and done pulse
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_IDLE;
      o_done <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      o_done <= (state != ST_IDLE) && (next_state == ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Burst and beat counters
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      nbursts <= '0;
      aw_cnt <= '0;
      w_burst <= '0;
      w_beat <= '0;
      b_cnt <= '0;
    end else if (start_wr || start_rd) begin
      nbursts <= next_nbursts;
      aw_cnt <= '0;
      w_burst <= '0;
      w_beat <= '0;
      b_cnt <= '0;
    end else begin
      aw_cnt <= aw_cnt + 12'(aw_fire);
      w_beat <= w_beat + 4'(w_fire);
      w_burst <= w_burst + 12'(w_end);
      b_cnt <= b_cnt + 12'(b_fire);
    end
  end

  // Read side counters
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ar_cnt <= '0;
      r_burst <= '0;
      r_beat <= '0;
    end else if (start_rd) begin
      ar_cnt <= '0;
      r_burst <= '0;
      r_beat <= '0;
    end else begin
      ar_cnt <= ar_cnt + 12'(ar_fire);
      r_beat <= r_beat + 4'(r_fire);
      r_burst <= r_burst + 12'(r_fire && axi.rlast);
    end
  end

  // ----------------------------------------------------------------
  // Clock counter, loaded with one as each operation starts
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      running <= 1'b0;
      o_count <= '0;
    end else if (i_ce) begin
      if (start_wr || start_rd) begin
        running <= 1'b1;
        o_count <= 32'h00000001;
      end else if (running && (w_final || r_final)) begin
        running <= 1'b0; // Final last beat is already counted
      end else if (running) begin
        o_count <= o_count + 32'h00000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Error flags
  // ----------------------------------------------------------------
  // Mismatch holds until the next read begins; a hit that cycle still sets
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      err <= 1'b0;
      o_bresp_err <= 1'b0;
    end else if (i_ce) begin
      if (r_wrong) begin
        err <= 1'b1;
      end else if (start_rd) begin
        err <= 1'b0;
      end
      if (b_bad) begin
        o_bresp_err <= 1'b1;
      end else if (start_wr) begin
        o_bresp_err <= 1'b0;
      end
    end
  end
endmodule

/* File: verification/ddr_tp_asserts.sv */
// Concurrent checks on the AXI channels between master and memory end
`timescale 1ns/1ps
module ddr_tp_asserts (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [31:0] awaddr,
  input wire logic [7:0] awlen,
  input wire logic [2:0] awsize,
  input wire logic [1:0] awburst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wlast,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic [7:0] arlen,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rlast,
  input wire logic rvalid,
  input wire logic rready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  logic [3:0] wbeat;
  logic [3:0] rbeat;
  logic [9:0] aw_open; // Bursts addressed but data not finished
  logic [9:0] b_open; // Bursts finished but not answered
  logic [9:0] ar_open; // Read bursts addressed but not returned
  wire aw_hs = awvalid && awready;
  wire w_hs = wvalid && wready;
  wire wl_hs = w_hs && wlast;
  wire b_hs = bvalid && bready;
  wire ar_hs = arvalid && arready;
  wire r_hs = rvalid && rready;
  wire rl_hs = r_hs && rlast;
  // Beat and outstanding counts
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wbeat <= 4'h0;
      rbeat <= 4'h0;
      aw_open <= 10'h0;
      b_open <= 10'h0;
      ar_open <= 10'h0;
    end else begin
      wbeat <= wbeat + 4'(w_hs);
      rbeat <= rbeat + 4'(r_hs);
      aw_open <= aw_open + 10'(aw_hs) - 10'(wl_hs);
      b_open <= b_open + 10'(wl_hs) - 10'(b_hs);
      ar_open <= ar_open + 10'(ar_hs) - 10'(rl_hs);
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_wlast_beat: assert property (w_hs |-> (wlast == (wbeat == 4'hF)))
    else $error("write last flag off the sixteenth beat");
  a_aw_shape: assert property (awvalid |-> awlen == ddr_tp_pkg::BURST_LEN
    && awsize == ddr_tp_pkg::BEAT_SIZE && awburst == ddr_tp_pkg::BURST_INCR)
    else $error("write burst shape wrong");
  a_ar_shape: assert property (arvalid |-> arlen == ddr_tp_pkg::BURST_LEN)
    else $error("read burst length wrong");
  a_aw_step: assert property (aw_hs ##1 awvalid |->
    awaddr == $past(awaddr) + ddr_tp_pkg::BURST_BYTES)
    else $error("write address step wrong");
  a_aw_hold: assert property (awvalid && !awready |=> awvalid && $stable(awaddr))
    else $error("write address dropped before accepted");
  a_ar_step: assert property (ar_hs ##1 arvalid |->
    araddr == $past(araddr) + ddr_tp_pkg::BURST_BYTES)
    else $error("read address step wrong");
  a_start_zero: assert property ($rose(awvalid) || $rose(arvalid) |->
    (awvalid ? awaddr : araddr) == ddr_tp_pkg::BASE_ADDR)
    else $error("operation does not start at address zero");
  a_w_after_aw: assert property (wvalid |-> aw_open != 10'h0)
    else $error("write data without an accepted address");
  a_resp_after_data: assert property (bvalid |-> b_open != 10'h0)
    else $error("write response before all beats");
  a_read_depth: assert property (ar_hs |-> ar_open <= 10'h4)
    else $error("too many read bursts outstanding");
  a_rlast_beat: assert property (r_hs |-> (rlast == (rbeat == 4'hF)))
    else $error("read last flag off the sixteenth beat");
endmodule

/* File: verification/ddr_axi_throughput_master_tb.sv */
// Bench: master and memory end joined, plus a master facing a failing slave
`timescale 1ns/1ps
module ddr_axi_throughput_master_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic wr_cmd = 1'b0;
  logic rd_cmd = 1'b0;
  logic [2:0] size = 3'h0;
  logic stall = 1'b0;
  logic err_cmd = 1'b0;
  logic busy, done, led_n, berr, e_busy, e_berr;
  logic [31:0] count;
  logic [2:0] queued;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int e_aw = 0;
  int aw_n, w_n, wl_n, b_n, ar_n, r_n, rl_n, bad, cyc, last, run, max_run, max_q;
  bit live;
  ddr_axi_if bus ();
  ddr_axi_if ebus ();
  // ----------------------------------------
  // Design, checker and failing slave
  // ----------------------------------------
  ddr_tp_master i_ddr_tp_master (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_wr_cmd(wr_cmd),
    .i_rd_cmd(rd_cmd), .i_size(size), .o_busy(busy), .o_done(done), .o_count(count),
    .o_led_err_n(led_n), .o_bresp_err(berr), .axi(bus));
  ddr_tp_mem i_ddr_tp_mem (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_stall(stall),
    .o_rd_queued(queued), .axi(bus));
  ddr_tp_master i_ddr_tp_master_err (.i_clk(clk), .i_rstn(rstn), .i_ce(ce),
    .i_wr_cmd(err_cmd), .i_rd_cmd(1'b0), .i_size(3'h4), .o_busy(e_busy), .o_done(),
    .o_count(), .o_led_err_n(), .o_bresp_err(e_berr), .axi(ebus));
  ddr_tp_asserts i_ddr_tp_asserts (.i_clk(clk), .i_rstn(rstn), .awaddr(bus.awaddr),
    .awlen(bus.awlen), .awsize(bus.awsize), .awburst(bus.awburst), .awvalid(bus.awvalid),
    .awready(bus.awready), .wlast(bus.wlast), .wvalid(bus.wvalid), .wready(bus.wready),
    .bvalid(bus.bvalid), .bready(bus.bready), .araddr(bus.araddr), .arlen(bus.arlen),
    .arvalid(bus.arvalid), .arready(bus.arready), .rlast(bus.rlast), .rvalid(bus.rvalid),
    .rready(bus.rready));
  // Failing slave takes everything and answers each burst with an error
  assign ebus.awready = 1'b1;
  assign ebus.wready = 1'b1;
  assign ebus.arready = 1'b1;
  assign ebus.rvalid = 1'b0;
  assign ebus.rlast = 1'b0;
  assign ebus.rdata = 64'h0;
  assign ebus.rresp = ddr_tp_pkg::RESP_OKAY;
  assign ebus.bresp = ddr_tp_pkg::RESP_SLVERR;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) ebus.bvalid <= 1'b0;
    else if (ebus.wvalid && ebus.wlast) ebus.bvalid <= 1'b1;
    else if (ebus.bready) ebus.bvalid <= 1'b0;
  end
  // ----------------------------------------
  // Clock and channel monitor
  // ----------------------------------------
  initial begin
    forever #20 clk = ~clk;
  end
  // Counts handshakes, checks pattern and addresses, times each operation
  always @(posedge clk) begin
    cycles++;
    if (live || bus.awvalid || bus.arvalid) begin
      live = 1;
      cyc++;
    end
    if (bus.awvalid && bus.awready) begin
      bad += int'(bus.awaddr !== 32'(aw_n) * ddr_tp_pkg::BURST_BYTES);
      aw_n++;
    end
    if (bus.wvalid && bus.wready) begin
      bad += int'(bus.wdata !== 64'(w_n[15:0]));
      w_n++;
      wl_n += int'(bus.wlast);
      if (bus.wlast) last = cyc;
    end
    b_n += int'(bus.bvalid && bus.bready);
    if (bus.arvalid && bus.arready) begin
      bad += int'(bus.araddr !== 32'(ar_n) * ddr_tp_pkg::BURST_BYTES);
      ar_n++;
      run++;
      if (run > max_run) max_run = run;
    end else run = 0;
    if (bus.rvalid && bus.rready) begin
      r_n++;
      rl_n += int'(bus.rlast);
      if (bus.rlast) last = cyc;
    end
    if (int'(queued) > max_q) max_q = int'(queued);
    e_aw += int'(ebus.awvalid && ebus.awready);
    if (cycles == 40000) begin
      mismatches++;
      complete_run();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic start_op(input logic wr, input logic [2:0] sz);
    @(negedge clk);
    {aw_n, w_n, wl_n, b_n, ar_n, r_n, rl_n, bad, cyc, last, run, max_run, max_q} = 416'h0;
    live = 0;
    wr_cmd = wr;
    rd_cmd = !wr;
    size = sz;
    @(negedge clk);
    wr_cmd = 1'b0;
    rd_cmd = 1'b0;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 20000 && done !== 1'b1; i++) @(negedge clk);
    check(done, 1, "done pulse");
  endtask
  task automatic check_write(input int n);
    check(aw_n, n, "write bursts");
    check(wl_n, n, "write last count");
    check(w_n, n * 16, "write beats");
    check(b_n, n, "write responses");
    check(bad, 0, "write pattern or address");
    check(count, last, "write clock count");
    check(berr, 0, "write error flag");
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic scen_reset();
    check({busy, led_n, berr, queued}, 6'h10, "idle outputs");
    check(count, 0, "count after reset");
  endtask
  task automatic scen_write_stall();
    stall = 1'b1;
    start_op(1'b1, 3'h0);
    repeat (30) @(negedge clk);
    check(w_n, ddr_tp_pkg::FIFO_DEPTH, "beats buffered while stalled");
    check({bus.wvalid, bus.wready, bus.bvalid}, 3'h4, "buffer full, no response");
    stall = 1'b0;
    wait_done();
    check_write(16);
  endtask
  task automatic scen_write_sizes();
    for (int s = 1; s < 6; s++) begin
      start_op(1'b1, 3'(s));
      wait_done();
      check_write(16 << (s > 4 ? 4 : s));
    end
  endtask
  task automatic scen_read_mismatch();
    start_op(1'b0, 3'h0);
    wait_done();
    check(led_n, 0, "mismatch lights indicator");
    check(rl_n, 16, "read bursts");
    check(count, last, "read clock count");
    start_op(1'b1, 3'h0);
    wait_done();
    check(led_n, 0, "indicator held over a write");
  endtask
  task automatic scen_read_clean();
    start_op(1'b0, 3'h0);
    wait_done();
    check(led_n, 1, "indicator cleared by clean read");
    check(r_n, 256, "read beats");
    check(bad, 0, "read addresses");
    check(max_q, ddr_tp_pkg::RD_QUEUE, "queued reads");
    check(max_run, 5, "back to back read addresses");
    check(count, last, "read clock count");
  endtask
  task automatic scen_bresp_err();
    @(negedge clk);
    err_cmd = 1'b1;
    @(negedge clk);
    err_cmd = 1'b0;
    for (int i = 0; i < 5000 && e_busy === 1'b1; i++) @(negedge clk);
    check(e_busy, 0, "error run ends");
    check(e_berr, 1, "write error flag");
    check(32'(e_aw < 256), 1, "no new bursts after error");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    scen_reset();
    scen_write_stall();
    scen_write_sizes();
    scen_read_mismatch();
    scen_read_clean();
    scen_bresp_err();
    complete_run();
  end
endmodule
